// file: rtl/msi_ctrl.sv
// multi-status indicator and monitor led control
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "msi_cfg.svh"
module msi_ctrl #(
  parameter logic [23:0] STEP_CYC = 24'(`MSI_STEP_CYC)
)(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [7:0] internal_event,
  input wire logic [1:0] manipulated_output,
  input wire logic [3:0] digital_input,
  input wire logic [4:0] internal_contact,
  input wire logic [3:0] comm_digital_input,
  input wire logic manual_mode,
  input wire logic ready_mode,
  input wire logic remote_setpoint,
  input wire logic auto_tuning,
  input wire logic ramping,
  input wire logic any_alarm,
  input wire logic process_value_alarm,
  input wire logic mode_key_held,
  input wire logic event_terminal,
  input wire logic signed [15:0] process_value,
  input wire logic signed [15:0] setpoint,
  input wire logic [6:0] out_percent,
  input wire logic [6:0] heat_percent,
  input wire logic [6:0] cool_percent,
  input wire logic [6:0] valve_percent,
  input wire logic link_tx_byte,
  input wire logic link_rx_byte,
  input wire logic two_current_inputs,
  output logic [7:0] multi_status_indicator,
  output logic monitor_led,
  output logic [1:0] current_display_select,
  output logic [1:0] access_level_setting
);
  import msi_pkg::*;

  msi_state_s st_reg;
  msi_state_s st_next;

  // ******************************************************
  // condition decode
  // ******************************************************
  function automatic logic cond_met(input logic [5:0] c);
    logic r;
    r = 1'b0;
    if (c == 6'h01)
      r = 1'b1;
    else if (c >= `MSI_C_EVT_LO && c <= `MSI_C_EVT_HI)
      r = internal_event[3'(c - `MSI_C_EVT_LO)];
    else if (c == `MSI_C_OUT1)
      r = manipulated_output[0];
    else if (c == `MSI_C_OUT2)
      r = manipulated_output[1];
    else if (c >= `MSI_C_DIN_LO && c <= `MSI_C_DIN_HI)
      r = digital_input[2'(c - `MSI_C_DIN_LO)];
    else if (c >= `MSI_C_CON_LO && c <= `MSI_C_CON_HI)
      r = internal_contact[3'(c - `MSI_C_CON_LO)];
    else if (c >= `MSI_C_CDI_LO && c <= `MSI_C_CDI_HI)
      r = comm_digital_input[2'(c - `MSI_C_CDI_LO)];
    else
    begin
      // named states; code 0 and undefined codes stay unmet
      unique case (c)
        `MSI_C_MANUAL: r = manual_mode;
        `MSI_C_READY: r = ready_mode;
        `MSI_C_RSP: r = remote_setpoint;
        `MSI_C_AT: r = auto_tuning;
        `MSI_C_RAMP: r = ramping;
        `MSI_C_ALARM: r = any_alarm;
        `MSI_C_PVALM: r = process_value_alarm;
        `MSI_C_MODEKEY: r = mode_key_held;
        `MSI_C_EVTTERM: r = event_terminal;
        default: r = 1'b0;
      endcase
    end
    return r;
  endfunction

  // bar of n lit segments from a 0..100 percent value
  function automatic msi_seg_t bar_from_pct(input logic [6:0] p);
    msi_seg_t s;
    logic [10:0] lit;
    s = '0;
    lit = (11'(p) * 11'(`MSI_SEG) + 11'd99) / 11'd100;
    for (int i = 0; i < `MSI_SEG; i++)
      s[i] = (11'(i) < lit);
    return s;
  endfunction

  // ******************************************************
  // pattern generation
  // ******************************************************
  logic signed [16:0] dev;
  logic [16:0] dev_abs;
  logic [3:0] dev_pos;
  msi_seg_t pat_leds [0:15];
  logic top_met;
  logic sec_met;
  logic thr_met;
  logic [3:0] sel_pat;
  logic sel_on;
  logic step;

  assign dev = 17'(process_value) - 17'(setpoint);
  assign dev_abs = dev[16] ? 17'(-dev) : dev;
  assign step = (st_reg.step_cnt == STEP_CYC - 24'h000001);

  always_comb
  begin
    logic signed [19:0] scaled;
    logic signed [19:0] idx;
    scaled = '0;
    idx = '0;
    dev_pos = 4'h0;
    // deviation over band maps -band..+band onto segments 0..7
    if (st_reg.dev_band != 14'h0000)
    begin
      scaled = 20'(dev) * 20'sd4;
      idx = scaled / $signed({6'h00, st_reg.dev_band}) + 20'sd4;
      if (idx < 0)
        dev_pos = 4'h0;
      else if (idx > 20'sd7)
        dev_pos = 4'h7;
      else
        dev_pos = idx[3:0];
    end
  end

  generate
    genvar g;
    for (g = 0; g < 16; g++)
    begin : g_pat
      always_comb
      begin
        unique case (msi_pat_e'(g))
          MSI_PAT_ON: pat_leds[g] = 8'hFF;
          MSI_PAT_SLOW: pat_leds[g] = {8{st_reg.phase[3]}};
          MSI_PAT_DOUBLE: pat_leds[g] =
            {8{st_reg.phase[3:2] == 2'h0 && st_reg.phase[0]}};
          MSI_PAT_FAST: pat_leds[g] = {8{st_reg.phase[0]}};
          MSI_PAT_SWEEP_LR: pat_leds[g] = 8'h80 >> st_reg.pos;
          MSI_PAT_SWEEP_RL: pat_leds[g] = 8'h01 << st_reg.pos;
          MSI_PAT_SWEEP_BF: pat_leds[g] = 8'h01 << st_reg.pos;
          MSI_PAT_DEV_OK: pat_leds[g] =
            {8{dev_abs <= 17'(st_reg.dev_band)}};
          MSI_PAT_DEV_BAR: pat_leds[g] = (st_reg.dev_band == 14'h0000)
            ? 8'h00 : 8'h01 << dev_pos[2:0];
          MSI_PAT_OUT_BAR: pat_leds[g] = bar_from_pct(out_percent);
          MSI_PAT_HEAT_BAR: pat_leds[g] = bar_from_pct(heat_percent);
          MSI_PAT_COOL_BAR: pat_leds[g] = bar_from_pct(cool_percent);
          MSI_PAT_VALVE_BAR: pat_leds[g] = bar_from_pct(valve_percent);
          MSI_PAT_DIN_MON: pat_leds[g] = {4'h0, digital_input};
          MSI_PAT_CON_MON: pat_leds[g] = {3'h0, internal_contact};
          MSI_PAT_EVT_MON: pat_leds[g] = internal_event;
        endcase
      end
    end
  endgenerate

  // ******************************************************
  // priority selection
  // ******************************************************
  always_comb
  begin
    top_met = cond_met(st_reg.top_cond);
    sec_met = cond_met(st_reg.sec_cond);
    thr_met = cond_met(st_reg.thr_cond);
    sel_on = 1'b1;
    if (top_met)
      sel_pat = st_reg.top_pat;
    else if (sec_met)
      sel_pat = st_reg.sec_pat;
    else if (thr_met)
      sel_pat = st_reg.thr_pat;
    else
    begin
      sel_pat = 4'h0;
      sel_on = 1'b0;
    end
  end

  // ******************************************************
  // next state
  // ******************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.rdata = 16'h0000;
    // step timer drives all blink and sweep rates
    st_next.step_cnt = step ? 24'h000000 : st_reg.step_cnt + 24'h000001;
    if (link_tx_byte)
      st_next.tx_seen = 1'b1;
    if (link_rx_byte)
      st_next.rx_seen = 1'b1;
    if (step)
    begin
      st_next.phase = st_reg.phase + 4'h1;
      if (st_reg.bounce_dir)
      begin
        st_next.pos = st_reg.pos - 3'h1;
        if (st_reg.pos == 3'h1)
          st_next.bounce_dir = 1'b0;
      end
      else
      begin
        st_next.pos = st_reg.pos + 3'h1;
        if (st_reg.pos == 3'h6 && sel_pat == 4'(MSI_PAT_SWEEP_BF))
          st_next.bounce_dir = 1'b1;
      end
      // activity seen in a step is shown in the next; a flag set in the
      // same cycle survives the clear
      st_next.tx_seen = link_tx_byte;
      st_next.rx_seen = link_rx_byte;
      unique case (st_reg.mon_sel)
        3'(MSI_MON_LINK): st_next.mon_led =
          (st_reg.tx_seen | st_reg.rx_seen) & ~st_reg.mon_led;
        3'(MSI_MON_TX): st_next.mon_led =
          st_reg.tx_seen & ~st_reg.mon_led;
        3'(MSI_MON_RX): st_next.mon_led =
          st_reg.rx_seen & ~st_reg.mon_led;
        3'(MSI_MON_READY): st_next.mon_led =
          ready_mode & ~st_reg.mon_led;
        default: st_next.mon_led = 1'b0;
      endcase
    end
    if (st_reg.mon_sel == 3'(MSI_MON_DIN_OR))
      st_next.mon_led = |digital_input;
    else if (st_reg.mon_sel == 3'(MSI_MON_OFF) ||
             st_reg.mon_sel > 3'(MSI_MON_READY))
      st_next.mon_led = 1'b0;
    st_next.leds = sel_on ? pat_leds[sel_pat] : 8'h00;

    if (reg_wr)
    begin
      unique case (reg_addr)
        `MSI_ADDR_TOP_COND: st_next.top_cond = reg_wdata[5:0];
        `MSI_ADDR_TOP_PAT: st_next.top_pat = reg_wdata[3:0];
        `MSI_ADDR_SEC_COND: st_next.sec_cond = reg_wdata[5:0];
        `MSI_ADDR_SEC_PAT: st_next.sec_pat = reg_wdata[3:0];
        `MSI_ADDR_THR_COND: st_next.thr_cond = reg_wdata[5:0];
        `MSI_ADDR_THR_PAT: st_next.thr_pat = reg_wdata[3:0];
        `MSI_ADDR_DEV_BAND:
          if (reg_wdata[13:0] <= `MSI_DEV_BAND_MAX && reg_wdata[15:14] == 0)
            st_next.dev_band = reg_wdata[13:0];
        `MSI_ADDR_MON_SEL:
          if (reg_wdata[2:0] <= 3'(MSI_MON_READY))
            st_next.mon_sel = reg_wdata[2:0];
        `MSI_ADDR_CUR_SEL:
          // only settable when both current inputs are fitted
          if (two_current_inputs && reg_wdata[1:0] != 2'h3)
            st_next.cur_sel = reg_wdata[1:0];
        `MSI_ADDR_ACCESS:
          if (reg_wdata[1:0] != 2'h3)
            st_next.access = reg_wdata[1:0];
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        `MSI_ADDR_TOP_COND: st_next.rdata = {10'h000, st_reg.top_cond};
        `MSI_ADDR_TOP_PAT: st_next.rdata = {12'h000, st_reg.top_pat};
        `MSI_ADDR_SEC_COND: st_next.rdata = {10'h000, st_reg.sec_cond};
        `MSI_ADDR_SEC_PAT: st_next.rdata = {12'h000, st_reg.sec_pat};
        `MSI_ADDR_THR_COND: st_next.rdata = {10'h000, st_reg.thr_cond};
        `MSI_ADDR_THR_PAT: st_next.rdata = {12'h000, st_reg.thr_pat};
        `MSI_ADDR_DEV_BAND: st_next.rdata = {2'h0, st_reg.dev_band};
        `MSI_ADDR_MON_SEL: st_next.rdata = {13'h0000, st_reg.mon_sel};
        `MSI_ADDR_CUR_SEL: st_next.rdata = {14'h0000, st_reg.cur_sel};
        `MSI_ADDR_ACCESS: st_next.rdata = {14'h0000, st_reg.access};
        `MSI_ADDR_STATUS: st_next.rdata = {3'h0, st_reg.mon_led,
          thr_met, sec_met, top_met, sel_on, st_reg.leds};
        default: st_next.rdata = 16'h0000;
      endcase
    end
  end

  // ******************************************************
  // state register
  // ******************************************************
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= '0;
      st_reg.top_cond <= `MSI_RST_TOP_COND;
      st_reg.top_pat <= `MSI_RST_TOP_PAT;
      st_reg.sec_cond <= `MSI_RST_SEC_COND;
      st_reg.sec_pat <= `MSI_RST_SEC_PAT;
      st_reg.thr_cond <= `MSI_RST_THR_COND;
      st_reg.thr_pat <= `MSI_RST_THR_PAT;
      st_reg.dev_band <= `MSI_RST_DEV_BAND;
      st_reg.mon_sel <= `MSI_RST_MON_SEL;
      st_reg.cur_sel <= `MSI_RST_CUR_SEL;
      st_reg.access <= `MSI_RST_ACCESS;
    end
    else
      st_reg <= st_next;
  end

  assign reg_rdata = st_reg.rdata;
  assign multi_status_indicator = st_reg.leds;
  assign monitor_led = st_reg.mon_led;
  // without two inputs nothing is offered
  assign current_display_select =
    two_current_inputs ? st_reg.cur_sel : 2'h0;
  assign access_level_setting = st_reg.access;
endmodule

// file: shared/msi_cfg.svh
// constants for the multi-status indicator control block
`ifndef MSI_CFG_SVH
`define MSI_CFG_SVH
// register offsets (word addresses on the plain register port)
`define MSI_ADDR_TOP_COND 4'h0
`define MSI_ADDR_TOP_PAT 4'h1
`define MSI_ADDR_SEC_COND 4'h2
`define MSI_ADDR_SEC_PAT 4'h3
`define MSI_ADDR_THR_COND 4'h4
`define MSI_ADDR_THR_PAT 4'h5
`define MSI_ADDR_DEV_BAND 4'h6
`define MSI_ADDR_MON_SEL 4'h7
`define MSI_ADDR_CUR_SEL 4'h8
`define MSI_ADDR_ACCESS 4'h9
`define MSI_ADDR_STATUS 4'hA
// reset values
`define MSI_RST_TOP_COND 6'h27
`define MSI_RST_TOP_PAT 4'h1
`define MSI_RST_SEC_COND 6'h2C
`define MSI_RST_SEC_PAT 4'h6
`define MSI_RST_THR_COND 6'h01
`define MSI_RST_THR_PAT 4'h9
`define MSI_RST_DEV_BAND 14'h0005
`define MSI_DEV_BAND_MAX 14'h270F
`define MSI_RST_MON_SEL 3'h0
`define MSI_RST_CUR_SEL 2'h0
`define MSI_RST_ACCESS 2'h1
// condition codes
`define MSI_C_EVT_LO 6'h02
`define MSI_C_EVT_HI 6'h09
`define MSI_C_OUT1 6'h0E
`define MSI_C_OUT2 6'h0F
`define MSI_C_DIN_LO 6'h12
`define MSI_C_DIN_HI 6'h15
`define MSI_C_CON_LO 6'h1A
`define MSI_C_CON_HI 6'h1E
`define MSI_C_CDI_LO 6'h22
`define MSI_C_CDI_HI 6'h25
`define MSI_C_MANUAL 6'h26
`define MSI_C_READY 6'h27
`define MSI_C_RSP 6'h28
`define MSI_C_AT 6'h29
`define MSI_C_RAMP 6'h2A
`define MSI_C_ALARM 6'h2C
`define MSI_C_PVALM 6'h2D
`define MSI_C_MODEKEY 6'h2F
`define MSI_C_EVTTERM 6'h30
// timing: step period in microseconds, cycles at 20 MHz
`define MSI_CLK_MHZ 20
`define MSI_STEP_US 50000
`define MSI_STEP_CYC (`MSI_STEP_US * `MSI_CLK_MHZ)
`define MSI_SEG 8
`endif

// file: shared/msi_pkg.sv
// types for the multi-status indicator control block
package msi_pkg;
  typedef enum logic [3:0] {
    MSI_PAT_ON, MSI_PAT_SLOW, MSI_PAT_DOUBLE, MSI_PAT_FAST,
    MSI_PAT_SWEEP_LR, MSI_PAT_SWEEP_RL, MSI_PAT_SWEEP_BF, MSI_PAT_DEV_OK,
    MSI_PAT_DEV_BAR, MSI_PAT_OUT_BAR, MSI_PAT_HEAT_BAR, MSI_PAT_COOL_BAR,
    MSI_PAT_VALVE_BAR, MSI_PAT_DIN_MON, MSI_PAT_CON_MON, MSI_PAT_EVT_MON
  } msi_pat_e;
  typedef enum logic [2:0] {
    MSI_MON_OFF, MSI_MON_LINK, MSI_MON_TX, MSI_MON_RX, MSI_MON_DIN_OR,
    MSI_MON_READY
  } msi_mon_e;
  typedef logic [7:0] msi_seg_t;
  typedef struct packed {
    logic [5:0] top_cond;
    logic [3:0] top_pat;
    logic [5:0] sec_cond;
    logic [3:0] sec_pat;
    logic [5:0] thr_cond;
    logic [3:0] thr_pat;
    logic [13:0] dev_band;
    logic [2:0] mon_sel;
    logic [1:0] cur_sel;
    logic [1:0] access;
    logic [23:0] step_cnt;
    logic [3:0] phase;
    logic [2:0] pos;
    logic bounce_dir;
    logic tx_seen;
    logic rx_seen;
    logic [15:0] rdata;
    msi_seg_t leds;
    logic mon_led;
  } msi_state_s;
endpackage

// file: test/msi_ctrl_checker.sv
// port checks for the indicator control block
`timescale 1ns/1ps
module msi_ctrl_checker (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [3:0] digital_input,
  input wire logic two_current_inputs,
  input wire logic [7:0] multi_status_indicator,
  input wire logic monitor_led,
  input wire logic [1:0] current_display_select,
  input wire logic [1:0] access_level_setting
);
  logic [2:0] mon_q;
  logic st_q;
  // shadow of the monitor select; out of range writes are dropped
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mon_q <= 3'h0;
      st_q <= 1'b0;
    end
    else
    begin
      st_q <= reg_rd && reg_addr == 4'hA;
      if (reg_wr && reg_addr == 4'h7 && reg_wdata <= 16'h0005)
        mon_q <= reg_wdata[2:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_cur_gate;
    !two_current_inputs |-> current_display_select == 2'h0;
  endproperty
  a_cur_gate: assert property (p_cur_gate)
    else $error("current shown without two inputs");
  property p_cur_code;
    current_display_select != 2'h3;
  endproperty
  a_cur_code: assert property (p_cur_code)
    else $error("current select code 3");
  property p_acc_rst;
    $rose(arst_n) |-> access_level_setting == 2'h1;
  endproperty
  a_acc_rst: assert property (p_acc_rst)
    else $error("access level not standard after reset");
  property p_dark;
    st_q && !reg_rdata[8] |-> reg_rdata[7:0] == 8'h00;
  endproperty
  a_dark: assert property (p_dark)
    else $error("indicator lit with no condition met");
  property p_top_any;
    st_q && reg_rdata[9] |-> reg_rdata[8];
  endproperty
  a_top_any: assert property (p_top_any)
    else $error("top met but none met");
  property p_any_or;
    st_q |-> reg_rdata[8] == |reg_rdata[11:9];
  endproperty
  a_any_or: assert property (p_any_or)
    else $error("met flags disagree");
  property p_mon_off;
    mon_q == 3'h0 ##1 mon_q == 3'h0 |-> !monitor_led;
  endproperty
  a_mon_off: assert property (p_mon_off)
    else $error("monitor led lit while disabled");
  property p_mon_or;
    mon_q == 3'h4 ##1 mon_q == 3'h4 |-> monitor_led == $past(|digital_input);
  endproperty
  a_mon_or: assert property (p_mon_or)
    else $error("monitor led not input OR");
  property p_led_mirror;
    st_q |-> reg_rdata[7:0] == $past(multi_status_indicator);
  endproperty
  a_led_mirror: assert property (p_led_mirror)
    else $error("status leds differ from indicator");
  c_top: cover property (st_q && reg_rdata[9]);
  c_or: cover property (mon_q == 3'h4 && monitor_led);
  c_cur: cover property (current_display_select == 2'h2);
endmodule
bind msi_ctrl msi_ctrl_checker chk_i (.ref_clk, .arst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .digital_input,
  .two_current_inputs, .multi_status_indicator, .monitor_led,
  .current_display_select, .access_level_setting);

// file: test/msi_status_model.sv
// status sources feeding the indicator block
`timescale 1ns/1ps
module msi_status_model (
  input wire logic [5:0] code,
  input wire logic on,
  output logic [7:0] internal_event,
  output logic [1:0] manipulated_output,
  output logic [3:0] digital_input,
  output logic [4:0] internal_contact,
  output logic [3:0] comm_digital_input,
  output logic [8:0] flags
);
  // one source at a time, so a selector can never hit by accident
  always_comb
  begin
    internal_event = 8'h00;
    manipulated_output = 2'h0;
    digital_input = 4'h0;
    internal_contact = 5'h00;
    comm_digital_input = 4'h0;
    flags = 9'h000;
    if (on && code >= 6'h02 && code <= 6'h09)
      internal_event[3'(code - 6'h02)] = 1'b1;
    if (on && (code == 6'h0E || code == 6'h0F))
      manipulated_output[1'(code - 6'h0E)] = 1'b1;
    if (on && code >= 6'h12 && code <= 6'h15)
      digital_input[2'(code - 6'h12)] = 1'b1;
    if (on && code >= 6'h1A && code <= 6'h1E)
      internal_contact[3'(code - 6'h1A)] = 1'b1;
    if (on && code >= 6'h22 && code <= 6'h25)
      comm_digital_input[2'(code - 6'h22)] = 1'b1;
    if (on && code >= 6'h26 && code <= 6'h2A)
      flags[4'(code - 6'h26)] = 1'b1;
    if (on && (code == 6'h2C || code == 6'h2D))
      flags[4'(code - 6'h27)] = 1'b1;
    if (on && (code == 6'h2F || code == 6'h30))
      flags[4'(code - 6'h28)] = 1'b1;
  end
endmodule

// file: test/tb_msi_ctrl.sv
// self-checking bench for the indicator control block
`timescale 1ns/1ps
module tb_msi_ctrl;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [5:0] src_code = 6'h00;
  logic src_on = 1'b0;
  logic [7:0] internal_event;
  logic [1:0] manipulated_output;
  logic [3:0] digital_input;
  logic [4:0] internal_contact;
  logic [3:0] comm_digital_input;
  logic [8:0] flags;
  logic signed [15:0] process_value = 16'sh0000;
  logic signed [15:0] setpoint = 16'sh0000;
  logic [6:0] out_percent = 7'h00;
  logic link_tx_byte = 1'b0;
  logic link_rx_byte = 1'b0;
  logic two_current_inputs = 1'b1;
  logic [7:0] multi_status_indicator;
  logic monitor_led;
  logic [1:0] current_display_select;
  logic [1:0] access_level_setting;
  int n_fail = 0;
  int tests_run = 0;
  int ch_m [3] = '{2, 3, 5};
  always #25 ref_clk = ~ref_clk;
  // a short step keeps blink and sweep runs brief
  msi_ctrl #(.STEP_CYC(24'h000004)) uut (
    .ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .internal_event, .manipulated_output, .digital_input, .internal_contact,
    .comm_digital_input, .manual_mode(flags[0]), .ready_mode(flags[1]),
    .remote_setpoint(flags[2]), .auto_tuning(flags[3]), .ramping(flags[4]),
    .any_alarm(flags[5]), .process_value_alarm(flags[6]),
    .mode_key_held(flags[7]), .event_terminal(flags[8]), .process_value,
    .setpoint, .out_percent, .heat_percent(7'h00), .cool_percent(7'h00),
    .valve_percent(7'h00), .link_tx_byte, .link_rx_byte,
    .two_current_inputs, .multi_status_indicator, .monitor_led,
    .current_display_select, .access_level_setting);
  msi_status_model src (.code(src_code), .on(src_on), .internal_event,
    .manipulated_output, .digital_input, .internal_contact,
    .comm_digital_input, .flags);
  task automatic give_verdict;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h saw %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge ref_clk);
  endtask
  task automatic see(input string nm, input logic [7:0] e);
    repeat (3) @(posedge ref_clk);
    #1 chk(nm, 16'(multi_status_indicator), 16'(e));
    @(posedge ref_clk);
  endtask
  task automatic t_regs;
    logic [15:0] v;
    logic [15:0] rv [10] = '{16'h0027, 16'h0001, 16'h002C, 16'h0006,
      16'h0001, 16'h0009, 16'h0005, 16'h0000, 16'h0000, 16'h0001};
    for (int i = 0; i < 10; i++)
    begin
      rd(4'(i), v);
      chk("reset value", v, rv[i]);
    end
    rd(4'hF, v);
    chk("unmapped", v, 16'h0000);
  endtask
  task automatic t_codes;
    logic [15:0] v;
    logic e;
    for (int c = 0; c < 49; c++)
    begin
      wr(4'h0, 16'(c));
      for (int o = 0; o < 2; o++)
      begin
        src_code <= 6'(c);
        src_on <= o[0];
        repeat (2) @(posedge ref_clk);
        rd(4'hA, v);
        e = c == 1 || (o == 1 && c inside {[2:9], 14, 15, [18:21],
          [26:30], [34:42], 44, 45, 47, 48});
        chk("top met", 16'(v[9]), 16'(e));
      end
    end
  endtask
  task automatic t_prio;
    src_on <= 1'b0;
    out_percent <= 7'h32;
    wr(4'h1, 16'h0000);
    wr(4'h2, 16'h0001);
    wr(4'h3, 16'h0009);
    wr(4'h4, 16'h0001);
    wr(4'h5, 16'h000F);
    wr(4'h0, 16'h0001);
    see("top", 8'hFF);
    wr(4'h0, 16'h0000);
    see("second", 8'h0F);
    src_code <= 6'h05;
    src_on <= 1'b1;
    wr(4'h2, 16'h0000);
    see("third", 8'h08);
    wr(4'h4, 16'h0000);
    see("none", 8'h00);
  endtask
  task automatic t_dev;
    logic [15:0] v;
    wr(4'h0, 16'h0001);
    wr(4'h1, 16'h0007);
    wr(4'h6, 16'h0000);
    process_value <= 16'sh0010;
    setpoint <= 16'sh0010;
    see("dev equal", 8'hFF);
    process_value <= 16'sh0011;
    see("dev off", 8'h00);
    wr(4'h1, 16'h0008);
    see("bar zero", 8'h00);
    wr(4'h6, 16'h0004);
    process_value <= 16'sh0012;
    see("bar pos", 8'h40);
    wr(4'h6, 16'h270F);
    wr(4'h6, 16'h2710);
    rd(4'h6, v);
    chk("band max", v, 16'h270F);
    wr(4'h1, 16'h0004);
    repeat (3) @(posedge ref_clk);
    #1 chk("sweep", 16'($countones(multi_status_indicator)), 16'h0001);
    @(posedge ref_clk);
    wr(4'h1, 16'h000D);
    src_code <= 6'h13;
    src_on <= 1'b1;
    see("din mon", 8'h02);
  endtask
  task automatic t_mon;
    int ch;
    logic last;
    wr(4'h7, 16'h0004);
    src_code <= 6'h12;
    src_on <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk("input or", 16'(monitor_led), 16'h0001);
    @(posedge ref_clk);
    src_code <= 6'h27;
    foreach (ch_m[k])
    begin
      wr(4'h7, 16'(ch_m[k]));
      ch = 0;
      last = monitor_led;
      for (int i = 0; i < 200; i++)
      begin
        @(posedge ref_clk);
        link_tx_byte <= ch_m[k] == 2 && i % 4 == 0;
        link_rx_byte <= ch_m[k] == 3 && i % 4 == 0;
        src_on <= ch_m[k] == 5;
        // look after the edge has settled the registered led
        #1 ch += int'(monitor_led !== last);
        last = monitor_led;
      end
      chk("blink", 16'(ch > 1), 16'h0001);
    end
    wr(4'h7, 16'h0000);
  endtask
  task automatic t_cfg;
    logic [15:0] v;
    wr(4'h8, 16'h0002);
    #1 chk("cur two", 16'(current_display_select), 16'h0002);
    @(posedge ref_clk);
    two_current_inputs <= 1'b0;
    @(posedge ref_clk);
    #1 chk("cur one", 16'(current_display_select), 16'h0000);
    @(posedge ref_clk);
    for (int a = 0; a < 4; a++)
    begin
      wr(4'h9, 16'(a));
      rd(4'h9, v);
      chk("access", v, 16'(a == 3 ? 2 : a));
    end
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1 chk("access rst", 16'(access_level_setting), 16'h0001);
    @(posedge ref_clk);
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    t_regs;
    t_codes;
    t_prio;
    t_dev;
    t_mon;
    t_cfg;
    give_verdict;
  end
  initial
  begin
    #3000000;
    n_fail++;
    give_verdict;
  end
endmodule
